// ### core/lbmc_top.sv
// Summary of operation
// R1: Enable pin low disables, resets registers, ignores the bus, holds shutdown.
// R2: Enable pin high enables the device and accepts register writes.
// R3: Three string enable bits at 0x10 bits 3:1, all set after reset.
// R4: Host sets chip enable, then drives PWM or writes a nonzero code.
// R5: Reset gives chip enable set, PWM source, linear mapping.
// R6: Default settings enter standby at enable and watch the PWM input.
// R7: Nonzero PWM duty becomes an 11-bit code, linearly mapped by default.
// R8: Standby drops to shutdown-level consumption, keeping register contents.
// R9: Source field 0x11 bits 6:5: 00 bus code, 01 PWM, else product.
// R10: Chip enable clear means disabled, LEDs off, regardless of everything else.
// R11: Standby with LEDs off when no string, zero code, or PWM low.
// R12: Bit 7 of 0x11 selects exponential mapping when set, linear when clear.
// R13: Linear current is 37.806 uA plus 12.195 uA per code step.
// R14: Mappings cover codes 1 to 2047; code zero gives zero current.
// R15: Exponential current is 50 uA times 1.003040572 to the code.
// R16: Bus code is 0x18 bits 2:0 and 0x19; selection passes a ramper.
// R17: PWM is sampled and its measured duty becomes the code.
// R18: Product source is bus code times PWM code over 2047, truncated.
`timescale 1ns/100ps
module lbmc_top #(
    parameter int PWM_TIMEOUT_CYCLES = lbmc_pkg::PWM_TIMEOUT_CYC,
    parameter logic [6:0] DEV_ADDR = lbmc_pkg::I2C_DEV_ADDR
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Device pins
    input wire logic hardware_enable_pin_i,
    input wire logic pwm_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Driver control
    output logic [lbmc_pkg::CUR_W-1:0] led_current_na_o,
    output logic [2:0] string_en_o,
    output logic [lbmc_pkg::CODE_W-1:0] brightness_code_o,
    output lbmc_pkg::lbmc_state_e op_state_o,
    output logic shutdown_quiescent_current_o
);
    localparam int CW = lbmc_pkg::CODE_W;
    localparam int PW = $clog2(PWM_TIMEOUT_CYCLES + 1);
    localparam int PNUM_W = PW + CW;
    localparam int QNUM_W = 2 * CW;
    localparam int ACC_W = lbmc_pkg::CUR_W + lbmc_pkg::EXP_FRAC_W;
    localparam int PROD_W = ACC_W + 16;

    // Enable pin synchroniser and core reset
    logic hardware_enable_pin_s1, hardware_enable_pin_s2;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hardware_enable_pin_s1 <= 1'h0;
            hardware_enable_pin_s2 <= 1'h0;
        end else begin
            hardware_enable_pin_s1 <= hardware_enable_pin_i;
            hardware_enable_pin_s2 <= hardware_enable_pin_s1;
        end
    end
    wire core_rst = rst_i | ~hardware_enable_pin_s2; // [R1] [R2]

    // Register file behind the bus slave
    lbmc_reg_if reg_bus();

    lbmc_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .ref_clk_i(ref_clk_i),
        .rst_i(core_rst), // [R1]
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .bus(reg_bus.master)
    );

    logic [7:0] enable_control, brightness_config;
    logic [7:0] brightness_code_high, brightness_code_low;

    wire sel_en = reg_bus.addr == lbmc_pkg::ADDR_ENABLE_CTRL;
    wire sel_cfg = reg_bus.addr == lbmc_pkg::ADDR_BRT_CFG;
    wire sel_hi = reg_bus.addr == lbmc_pkg::ADDR_CODE_HIGH;
    wire sel_lo = reg_bus.addr == lbmc_pkg::ADDR_CODE_LOW;
    wire [7:0] wd = reg_bus.wr_data;

    assign reg_bus.rd_data = sel_en ? enable_control :
                             sel_cfg ? brightness_config :
                             sel_hi ? brightness_code_high :
                             sel_lo ? brightness_code_low : 8'h00;

    // Registers survive standby and chip disable; only the pin or rst_i clears them
    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            enable_control <= lbmc_pkg::ENABLE_CTRL_RST; // [R1] [R3] [R5]
            brightness_config <= lbmc_pkg::BRT_CFG_RST; // [R5]
            brightness_code_high <= lbmc_pkg::CODE_HIGH_RST;
            brightness_code_low <= lbmc_pkg::CODE_LOW_RST;
        end else if (reg_bus.wr_en) begin // [R2] [R8]
            if (sel_en) enable_control <= wd & lbmc_pkg::ENABLE_CTRL_MASK;
            if (sel_cfg) brightness_config <= wd & lbmc_pkg::BRT_CFG_MASK;
            if (sel_hi) brightness_code_high <= wd & lbmc_pkg::CODE_HIGH_MASK;
            if (sel_lo) brightness_code_low <= wd;
        end
    end

    // Field decode
    wire chip_en = enable_control[lbmc_pkg::CHIP_EN_BIT];
    wire [2:0] strings = enable_control[lbmc_pkg::STR_EN_MSB:lbmc_pkg::STR_EN_LSB]; // [R3]
    wire [1:0] src_sel = brightness_config[lbmc_pkg::SRC_MSB:lbmc_pkg::SRC_LSB];
    wire map_exp = brightness_config[lbmc_pkg::MAP_BIT]; // [R12]
    wire [CW-1:0] i2c_code = {brightness_code_high[lbmc_pkg::CODE_HIGH_MSB:0],
                              brightness_code_low}; // [R16]

    // PWM duty measurement, sampled on the core clock
    logic pwm_s1, pwm_s2, pwm_d, pwm_live;
    logic [PW-1:0] per_cnt, high_cnt, idle_cnt;
    logic [CW-1:0] pwm_code;

    wire pwm_rise = pwm_s2 & ~pwm_d;
    wire pwm_edge = pwm_s2 ^ pwm_d;
    wire pwm_timeout = idle_cnt == PW'(PWM_TIMEOUT_CYCLES);
    wire [PW-1:0] cnt_max = '1;
    wire pdiv_start = pwm_rise & pwm_live & (per_cnt != '0);
    wire [PNUM_W-1:0] pdiv_num = PNUM_W'(high_cnt) * PNUM_W'(lbmc_pkg::CODE_MAX);
    wire pdiv_done;
    wire [PNUM_W-1:0] pdiv_quot;

    // Long-running duty divide; edges faster than the divide time are skipped
    lbmc_divider #(
        .NUM_W(PNUM_W),
        .DEN_W(PW)
    ) u_pwm_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(core_rst),
        .start_i(pdiv_start), // [R17]
        .num_i(pdiv_num),
        .den_i(per_cnt),
        .busy_o(),
        .done_o(pdiv_done),
        .quot_o(pdiv_quot)
    );

    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            {pwm_s1, pwm_s2, pwm_d} <= 3'h0;
        end else begin
            {pwm_s1, pwm_s2, pwm_d} <= {pwm_i, pwm_s1, pwm_s2}; // [R17]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            per_cnt <= '0;
            high_cnt <= '0;
            idle_cnt <= '0;
        end else begin
            if (pwm_rise) begin
                per_cnt <= PW'(1);
                high_cnt <= PW'(1);
            end else begin
                if (per_cnt != cnt_max) per_cnt <= per_cnt + PW'(1);
                if (pwm_s2 && high_cnt != cnt_max) high_cnt <= high_cnt + PW'(1);
            end
            if (pwm_edge) idle_cnt <= '0;
            else if (!pwm_timeout) idle_cnt <= idle_cnt + PW'(1); // [R6]
        end
    end

    // A silent input reads as full or zero duty from its level
    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            pwm_live <= 1'h0;
            pwm_code <= '0;
        end else begin
            if (pwm_rise) pwm_live <= 1'h1;
            else if (pwm_timeout) pwm_live <= 1'h0;
            if (pwm_timeout) pwm_code <= pwm_s2 ? lbmc_pkg::CODE_MAX : '0; // [R11]
            else if (pdiv_done) pwm_code <= pdiv_quot[CW-1:0]; // [R7] [R17]
        end
    end

    // Product of both sources, recomputed continuously
    wire qdiv_busy;
    wire [QNUM_W-1:0] qdiv_quot;
    wire [QNUM_W-1:0] qdiv_num = QNUM_W'(i2c_code) * QNUM_W'(pwm_code);

    lbmc_divider #(
        .NUM_W(QNUM_W),
        .DEN_W(CW)
    ) u_prod_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(core_rst),
        .start_i(~qdiv_busy),
        .num_i(qdiv_num),
        .den_i(lbmc_pkg::CODE_MAX), // [R18]
        .busy_o(qdiv_busy),
        .done_o(),
        .quot_o(qdiv_quot)
    );
    wire [CW-1:0] prod_code = qdiv_quot[CW-1:0]; // [R18]

    // Source selection
    wire [CW-1:0] sel_code = (src_sel == lbmc_pkg::SRC_I2C) ? i2c_code :
                             (src_sel == lbmc_pkg::SRC_PWM) ? pwm_code :
                             prod_code; // [R9]

    // Operating state
    lbmc_pkg::lbmc_state_e state, next_state;
    always_comb begin
        if (!chip_en) begin
            next_state = lbmc_pkg::ST_DISABLED; // [R10]
        end else if (strings == 3'h0 || sel_code == '0) begin
            next_state = lbmc_pkg::ST_STANDBY; // [R4] [R6] [R11]
        end else begin
            next_state = lbmc_pkg::ST_ACTIVE;
        end
    end
    wire active = next_state == lbmc_pkg::ST_ACTIVE;

    // Ramper, one code step per clock towards the selection while active, else straight to zero
    logic [CW-1:0] ramp_code, next_ramp;
    always_comb begin
        if (!active) next_ramp = '0;
        else if (ramp_code < sel_code) next_ramp = ramp_code + CW'(1);
        else if (ramp_code > sel_code) next_ramp = ramp_code - CW'(1);
        else next_ramp = ramp_code; // [R16]
    end

    // Linear mapping
    wire [lbmc_pkg::CUR_W-1:0] lin_cur = lbmc_pkg::LIN_OFFSET_NA
        + lbmc_pkg::LIN_SLOPE_NA * lbmc_pkg::CUR_W'(ramp_code); // [R13]

    // Exponential mapping by repeated multiply; a falling code restarts
    // from the base, so large drops take up to full scale in cycles
    logic [CW-1:0] exp_idx;
    logic [ACC_W-1:0] exp_acc;
    wire [PROD_W-1:0] exp_prod = PROD_W'(exp_acc) * PROD_W'(lbmc_pkg::EXP_STEP_K);
    wire [ACC_W-1:0] exp_inc = ACC_W'(exp_prod >> lbmc_pkg::EXP_K_SHIFT);
    wire [ACC_W-1:0] exp_seed = {lbmc_pkg::EXP_BASE_NA, {lbmc_pkg::EXP_FRAC_W{1'h0}}};
    wire [lbmc_pkg::CUR_W-1:0] exp_cur = exp_acc[ACC_W-1:lbmc_pkg::EXP_FRAC_W];
    wire exp_ready = exp_idx == ramp_code;

    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            exp_idx <= '0;
            exp_acc <= '0;
        end else if (exp_idx > ramp_code || exp_acc == '0) begin
            exp_idx <= '0;
            exp_acc <= exp_seed;
        end else if (!exp_ready) begin
            exp_idx <= exp_idx + CW'(1);
            exp_acc <= exp_acc + exp_inc; // [R15]
        end
    end

    logic [lbmc_pkg::CUR_W-1:0] next_current;
    always_comb begin
        if (!active || ramp_code == '0) next_current = '0; // [R10] [R11] [R14]
        else if (!map_exp) next_current = lin_cur; // [R12] [R13]
        else if (exp_ready) next_current = exp_cur; // [R12] [R15]
        else next_current = led_current_na_o;
    end

    // Output registers
    always_ff @(posedge ref_clk_i) begin
        if (core_rst) begin
            state <= lbmc_pkg::ST_DISABLED; // [R1]
            ramp_code <= '0;
            led_current_na_o <= '0;
            string_en_o <= 3'h0;
            brightness_code_o <= '0;
            shutdown_quiescent_current_o <= 1'h1;
        end else begin
            state <= next_state;
            ramp_code <= next_ramp;
            led_current_na_o <= next_current;
            string_en_o <= (next_state == lbmc_pkg::ST_ACTIVE) ? strings : 3'h0; // [R3]
            brightness_code_o <= next_ramp;
            shutdown_quiescent_current_o <= next_state != lbmc_pkg::ST_ACTIVE; // [R8]
        end
    end
    assign op_state_o = state;
endmodule // lbmc_top

// ### core/lbmc_pkg.sv
package lbmc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_ENABLE_CTRL = 8'h10;
    localparam logic [7:0] ADDR_BRT_CFG = 8'h11;
    localparam logic [7:0] ADDR_CODE_HIGH = 8'h18;
    localparam logic [7:0] ADDR_CODE_LOW = 8'h19;

    // Reset values and writable bits
    localparam logic [7:0] ENABLE_CTRL_RST = 8'h0F;
    localparam logic [7:0] BRT_CFG_RST = 8'h20;
    localparam logic [7:0] CODE_HIGH_RST = 8'h00;
    localparam logic [7:0] CODE_LOW_RST = 8'h00;
    localparam logic [7:0] ENABLE_CTRL_MASK = 8'h0F;
    localparam logic [7:0] BRT_CFG_MASK = 8'hE0;
    localparam logic [7:0] CODE_HIGH_MASK = 8'h07;

    // Field positions
    localparam int CHIP_EN_BIT = 32'h0000_0000;
    localparam int STR_EN_LSB = 32'h0000_0001;
    localparam int STR_EN_MSB = 32'h0000_0003;
    localparam int SRC_LSB = 32'h0000_0005;
    localparam int SRC_MSB = 32'h0000_0006;
    localparam int MAP_BIT = 32'h0000_0007;
    localparam int CODE_HIGH_MSB = 32'h0000_0002;

    // Brightness source encodings
    localparam logic [1:0] SRC_I2C = 2'h0;
    localparam logic [1:0] SRC_PWM = 2'h1;

    // Code and current scaling, currents in nanoamps
    localparam int CODE_W = 32'h0000_000B;
    localparam logic [10:0] CODE_MAX = 11'h7FF;
    localparam int CUR_W = 32'h0000_0019;
    localparam logic [24:0] LIN_OFFSET_NA = 25'h93AE;
    localparam logic [24:0] LIN_SLOPE_NA = 25'h2FA3;
    localparam logic [24:0] EXP_BASE_NA = 25'hC350;
    localparam int EXP_FRAC_W = 32'h0000_0010;
    localparam logic [15:0] EXP_STEP_K = 16'hC744;
    localparam int EXP_K_SHIFT = 32'h0000_0018;

    // Timing
    localparam int CLK_MHZ = 32'h0000_000A;
    localparam int PWM_TIMEOUT_US = 32'h0000_61A8;
    localparam int PWM_TIMEOUT_CYC = PWM_TIMEOUT_US * CLK_MHZ;

    // Bus slave; address value is arbitrary
    localparam logic [6:0] I2C_DEV_ADDR = 7'h2C;
    localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_DISABLED = 3'b001,
        ST_STANDBY = 3'b010,
        ST_ACTIVE = 3'b100
    } lbmc_state_e;

    typedef enum logic [3:0] {
        I2C_IDLE = 4'b0001,
        I2C_ADDR = 4'b0010,
        I2C_REG = 4'b0100,
        I2C_DATA = 4'b1000
    } lbmc_i2c_e;
endpackage

// ### core/lbmc_reg_if.sv
`timescale 1ns/100ps
interface lbmc_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport master(output wr_en, output addr, output wr_data, input rd_data);
    modport regs(input wr_en, input addr, input wr_data, output rd_data);
endinterface

// ### core/lbmc_divider.sv
`timescale 1ns/100ps
module lbmc_divider #(
    parameter int NUM_W = 29,
    parameter int DEN_W = 18
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Request
    input wire logic start_i,
    input wire logic [NUM_W-1:0] num_i,
    input wire logic [DEN_W-1:0] den_i,
    // Answer
    output logic busy_o,
    output logic done_o,
    output logic [NUM_W-1:0] quot_o
);
    localparam int CNT_W = $clog2(NUM_W + 1);

    logic [DEN_W:0] rem;
    logic [NUM_W-1:0] q;
    logic [DEN_W-1:0] den;
    logic [CNT_W-1:0] cnt;

    wire [DEN_W:0] rem_sh = {rem[DEN_W-1:0], q[NUM_W-1]};
    wire fits = rem_sh >= {1'h0, den};
    wire [DEN_W:0] rem_nx = fits ? rem_sh - {1'h0, den} : rem_sh;
    wire [NUM_W-1:0] q_nx = {q[NUM_W-2:0], fits};

    // One quotient bit per cycle; a start while busy is dropped
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'h0;
            done_o <= 1'h0;
            rem <= '0;
            q <= '0;
            den <= '0;
            cnt <= '0;
            quot_o <= '0;
        end else begin
            done_o <= 1'h0;
            if (start_i && !busy_o) begin
                busy_o <= 1'h1;
                rem <= '0;
                q <= num_i;
                den <= den_i;
                cnt <= CNT_W'(NUM_W);
            end else if (busy_o) begin
                rem <= rem_nx;
                q <= q_nx;
                cnt <= cnt - CNT_W'(1);
                if (cnt == CNT_W'(1)) begin
                    busy_o <= 1'h0;
                    done_o <= 1'h1;
                    quot_o <= q_nx;
                end
            end
        end
    end
endmodule // lbmc_divider

// ### core/lbmc_i2c_slave.sv
`timescale 1ns/100ps
module lbmc_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = lbmc_pkg::I2C_DEV_ADDR
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Register side
    lbmc_reg_if.master bus
);
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    lbmc_pkg::lbmc_i2c_e state;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic ack_ph, ack_drv, nack, wr_en, rd_mode;
    logic [7:0] ptr;

    wire start_w = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire stop_w = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire rise = scl_s2 & ~scl_d;
    wire fall = ~scl_s2 & scl_d;
    wire at_end = cnt == lbmc_pkg::I2C_BYTE_BITS;
    wire byte_done = fall & at_end & ~ack_ph;
    wire ack_end = fall & ack_ph;
    wire addr_hit = sh[7:1] == DEV_ADDR;
    wire in_data = state == lbmc_pkg::I2C_DATA;
    wire tx = in_data & rd_mode;

    assign bus.addr = ptr;
    assign bus.wr_data = sh;
    assign bus.wr_en = wr_en;
    assign sda_o = 1'h0;
    assign sda_oe_o = (ack_ph & ack_drv) | (tx & ~ack_ph & ~sh[7]);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
        end else begin
            {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= lbmc_pkg::I2C_IDLE;
            sh <= 8'h00;
            cnt <= 4'h0;
            {ack_ph, ack_drv, nack, wr_en, rd_mode} <= 5'h00;
            ptr <= 8'h00;
        end else begin
            wr_en <= 1'h0;
            if (start_w) begin
                state <= lbmc_pkg::I2C_ADDR;
                cnt <= 4'h0;
                {ack_ph, ack_drv, rd_mode} <= 3'h0;
            end else if (stop_w) begin
                state <= lbmc_pkg::I2C_IDLE;
                {ack_ph, ack_drv, rd_mode} <= 3'h0;
            end else begin
                if (rise && !ack_ph && !at_end) begin
                    cnt <= cnt + 4'h1;
                    if (!tx) sh <= {sh[6:0], sda_s2};
                end
                if (rise && ack_ph) nack <= sda_s2;
                // Change read data only while the clock is low
                if (fall && tx && !ack_ph && !at_end && cnt != 4'h0) sh <= {sh[6:0], 1'h0};
                if (byte_done) begin
                    ack_ph <= 1'h1;
                    ack_drv <= (state == lbmc_pkg::I2C_ADDR && addr_hit)
                        || state == lbmc_pkg::I2C_REG || (in_data && !rd_mode);
                    wr_en <= in_data && !rd_mode;
                    if (state == lbmc_pkg::I2C_REG) ptr <= sh;
                end
                if (ack_end) begin
                    {ack_ph, ack_drv} <= 2'h0;
                    cnt <= 4'h0;
                    unique case (state)
                        lbmc_pkg::I2C_ADDR: begin
                            if (!addr_hit) begin
                                state <= lbmc_pkg::I2C_IDLE;
                            end else if (sh[0]) begin
                                state <= lbmc_pkg::I2C_DATA;
                                rd_mode <= 1'h1;
                                sh <= bus.rd_data;
                                ptr <= ptr + 8'h01;
                            end else begin
                                state <= lbmc_pkg::I2C_REG;
                            end
                        end
                        lbmc_pkg::I2C_REG: state <= lbmc_pkg::I2C_DATA;
                        lbmc_pkg::I2C_DATA: begin
                            if (rd_mode && nack) begin
                                state <= lbmc_pkg::I2C_IDLE;
                            end else begin
                                ptr <= ptr + 8'h01;
                                if (rd_mode) sh <= bus.rd_data;
                            end
                        end
                        lbmc_pkg::I2C_IDLE: ;
                        default: state <= lbmc_pkg::I2C_IDLE;
                    endcase
                end
            end
        end
    end
endmodule // lbmc_i2c_slave

// ### bench/lbmc_top_asserts.sv
`timescale 1ns/100ps
module lbmc_top_asserts (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Watched pins
    input wire logic hardware_enable_pin_i,
    input wire logic [lbmc_pkg::CUR_W-1:0] led_current_na_o,
    input wire logic [2:0] string_en_o,
    input wire logic [lbmc_pkg::CODE_W-1:0] brightness_code_o,
    input wire lbmc_pkg::lbmc_state_e op_state_o,
    input wire logic shutdown_quiescent_current_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // Sync and state flop latency
    sequence s_pin_low;
        !hardware_enable_pin_i [*5];
    endsequence
    sequence s_pin_rise;
        !hardware_enable_pin_i ##1 hardware_enable_pin_i [*3];
    endsequence
    sequence s_two_active;
        op_state_o == lbmc_pkg::ST_ACTIVE ##1 op_state_o == lbmc_pkg::ST_ACTIVE;
    endsequence
    a_pin_low_off: assert property (s_pin_low |-> op_state_o == lbmc_pkg::ST_DISABLED)
        else $error("not disabled while enable pin low");
    a_pin_rise_standby: assert property (
        s_pin_rise |-> ##[1:3] op_state_o == lbmc_pkg::ST_STANDBY)
        else $error("no standby after enable pin rise");
    a_idle_dark: assert property (op_state_o != lbmc_pkg::ST_ACTIVE |->
        led_current_na_o == 25'h000_0000 && string_en_o == 3'h0 && brightness_code_o == 11'h000)
        else $error("drive present outside active state");
    a_shdn_level: assert property (
        shutdown_quiescent_current_o == (op_state_o != lbmc_pkg::ST_ACTIVE))
        else $error("low power flag does not follow state");
    a_zero_code_off: assert property (
        brightness_code_o == 11'h000 |-> led_current_na_o == 25'h000_0000)
        else $error("current with zero code");
    a_ramp_unit_step: assert property (s_two_active |-> $stable(brightness_code_o) ||
        brightness_code_o - $past(brightness_code_o) == 11'h001 ||
        $past(brightness_code_o) - brightness_code_o == 11'h001)
        else $error("code jumped by more than one step");
    a_active_strings: assert property (
        op_state_o == lbmc_pkg::ST_ACTIVE |-> string_en_o != 3'h0)
        else $error("active with no string driven");
    a_state_legal: assert property (op_state_o inside {lbmc_pkg::ST_DISABLED,
        lbmc_pkg::ST_STANDBY, lbmc_pkg::ST_ACTIVE})
        else $error("illegal state code");
endmodule // lbmc_top_asserts

bind lbmc_top lbmc_top_asserts u_lbmc_chk (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .hardware_enable_pin_i(hardware_enable_pin_i),
    .led_current_na_o(led_current_na_o),
    .string_en_o(string_en_o),
    .brightness_code_o(brightness_code_o),
    .op_state_o(op_state_o),
    .shutdown_quiescent_current_o(shutdown_quiescent_current_o)
);

// ### bench/lbmc_host_model.sv
`timescale 1ns/100ps
module lbmc_host_model (
    // Clock and device pull-down
    input wire logic ref_clk_i,
    input wire logic sda_oe_i,
    // Driven pins
    output logic scl_o,
    output logic sda_o,
    output logic pwm_o
);
    logic sda_drv = 1'b1;
    int pwm_hi = 0;
    int pwm_per = 0;
    int pc = 0;
    int nacks = 0;
    // Pull-up wins unless the host or the device pulls low
    assign sda_o = sda_drv & (sda_oe_i !== 1'b1);
    initial begin
        scl_o = 1'b1;
        pwm_o = 1'b0;
    end
    always @(posedge ref_clk_i) begin
        #1;
        pc = (pc + 1 >= pwm_per) ? 0 : pc + 1;
        pwm_o = pc < pwm_hi;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // Data moves mid-low so it never races the clock edge
    task automatic put_bit(input logic b, output logic seen);
        tick(2);
        sda_drv = b;
        tick(4);
        scl_o = 1'b1;
        tick(5);
        seen = sda_o;
        tick(1);
        scl_o = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic reg_write(input logic [7:0] offs, input logic [7:0] d);
        logic ack;
        sda_drv = 1'b0;
        tick(6);
        scl_o = 1'b0;
        put_byte({lbmc_pkg::I2C_DEV_ADDR, 1'b0}, ack);
        if (!ack) begin
            nacks++;
        end else begin
            put_byte(offs, ack);
            put_byte(d, ack);
        end
        tick(2);
        sda_drv = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(6);
        sda_drv = 1'b1;
        tick(6);
    endtask
endmodule // lbmc_host_model

// ### bench/led_backlight_mode_control_tb.sv
`timescale 1ns/100ps
module led_backlight_mode_control_tb;
    typedef struct {
        logic [7:0] en;
        logic [7:0] cfg;
        logic [10:0] code;
        int hi;
        int per;
        lbmc_pkg::lbmc_state_e st;
        logic [10:0] want;
    } lbmc_row_s;
    localparam lbmc_pkg::lbmc_state_e ACT = lbmc_pkg::ST_ACTIVE;
    localparam lbmc_pkg::lbmc_state_e STB = lbmc_pkg::ST_STANDBY;
    localparam lbmc_pkg::lbmc_state_e DIS = lbmc_pkg::ST_DISABLED;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_en = 1'b1;
    logic scl, sda, pwm, sda_oe, shdn;
    logic [24:0] cur;
    logic [2:0] str;
    logic [10:0] code;
    lbmc_pkg::lbmc_state_e st;
    int num_errors = 0;
    int n_tests = 0;
    lbmc_row_s rows [10];
    always #50 ref_clk_i = ~ref_clk_i;
    lbmc_top #(.PWM_TIMEOUT_CYCLES(200)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .hardware_enable_pin_i(hw_en), .pwm_i(pwm), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(sda_oe), .led_current_na_o(cur), .string_en_o(str),
        .brightness_code_o(code), .op_state_o(st), .shutdown_quiescent_current_o(shdn));
    lbmc_host_model host (.ref_clk_i(ref_clk_i), .sda_oe_i(sda_oe), .scl_o(scl),
        .sda_o(sda), .pwm_o(pwm));
    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_eq(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic real want_cur(input logic [7:0] cfg, input logic [10:0] c);
        if (c == 11'h000) return 0.0;
        if (cfg[7]) return 50000.0 * (1.003040572 ** c);
        return 37806.0 + 12195.0 * c;
    endfunction
    // Fixed-point exponential gets a relative margin
    function automatic bit near(input logic [7:0] cfg, input logic [10:0] c);
        real w, d;
        w = want_cur(cfg, c);
        d = cur - w;
        w = w * (cfg[7] ? 0.005 : 0.0) + 0.5;
        return !$isunknown(cur) && d <= w && -d <= w;
    endfunction
    task automatic wait_for(input logic [7:0] cfg, input logic [10:0] c,
        input lbmc_pkg::lbmc_state_e s);
        int n;
        for (n = 0; n < 6000; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (code === c && st === s && near(cfg, c)) break;
        end
        n_tests++;
        if (n == 6000) begin
            num_errors++;
            $display("[ERR] %0t no settle at code %h", $time, c);
            final_report();
        end
    endtask
    initial begin
        rows = '{'{8'h0F, 8'h00, 11'h400, 0, 0, ACT, 11'h400},
            '{8'h03, 8'h80, 11'h7FF, 0, 0, ACT, 11'h7FF},
            '{8'h0F, 8'h20, 11'h000, 50, 100, ACT, 11'h3FF},
            '{8'h0F, 8'h40, 11'h3E8, 50, 100, ACT, 11'h1F3},
            '{8'h0F, 8'hE0, 11'h7FF, 25, 100, ACT, 11'h1FF},
            '{8'h0F, 8'h20, 11'h000, 100, 100, ACT, 11'h7FF},
            '{8'h0F, 8'h20, 11'h000, 0, 100, STB, 11'h000},
            '{8'h0F, 8'h00, 11'h000, 0, 0, STB, 11'h000},
            '{8'h01, 8'h00, 11'h005, 0, 0, STB, 11'h000},
            '{8'h0E, 8'h00, 11'h005, 0, 0, DIS, 11'h000}};
        repeat (12) @(posedge ref_clk_i);
        #1;
        check_eq(11'(st), 11'(DIS));
        rst_i = 1'b0;
        wait_for(8'h20, 11'h000, STB);
        foreach (rows[i]) begin
            host.reg_write(lbmc_pkg::ADDR_ENABLE_CTRL, rows[i].en);
            host.reg_write(lbmc_pkg::ADDR_BRT_CFG, rows[i].cfg);
            host.reg_write(lbmc_pkg::ADDR_CODE_HIGH, {5'h00, rows[i].code[10:8]});
            host.reg_write(lbmc_pkg::ADDR_CODE_LOW, rows[i].code[7:0]);
            host.pwm_hi = rows[i].hi;
            host.pwm_per = rows[i].per;
            wait_for(rows[i].cfg, rows[i].want, rows[i].st);
            check_eq(11'(str), rows[i].st == ACT ? 11'(rows[i].en[3:1]) : 11'h000);
        end
        host.pwm_hi = 50;
        host.pwm_per = 100;
        hw_en = 1'b0;
        wait_for(8'h20, 11'h000, DIS);
        host.reg_write(lbmc_pkg::ADDR_BRT_CFG, 8'h00);
        hw_en = 1'b1;
        wait_for(8'h20, 11'h3FF, ACT);
        check_eq(11'(str), 11'h007);
        check_eq(11'(host.nacks), 11'h001);
        final_report();
    end
endmodule // led_backlight_mode_control_tb
